/* dv/converter_control_regs_sva.sv */
`timescale 1ns/1ps
module conv_regs_checker (
    input wire logic       mclk_in,
    input wire logic       reset_n_in,
    input wire logic       io_supply_valid_in,
    input wire logic       input_undervoltage_lockout_in,
    input wire logic       enable_in,
    input wire logic       host_connected_in,
    input wire logic       reg_wr_in,
    input wire logic       reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       reg_rvalid_out,
    input wire logic       converter_run_out,
    input wire logic       forced_pwm_enable_out,
    input wire logic [1:0] switch_sel_a_out,
    input wire logic [7:0] ref_code_out
);
    // ====================
    // helper state
    logic       cfg_rst;
    logic       live;
    logic [1:0] quiet;
    logic [1:0] next_quiet;
    assign cfg_rst = !io_supply_valid_in || input_undervoltage_lockout_in || !enable_in;
    assign live = host_connected_in && !cfg_rst;
    // edges since the last configuration reset, saturating
    always_comb begin
        next_quiet = quiet;
        if (cfg_rst) begin
            next_quiet = 2'h0;
        end else if (quiet != 2'h3) begin
            next_quiet = quiet + 2'h1;
        end
    end
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            quiet <= 2'h0;
        end else begin
            quiet <= next_quiet;
        end
    end
    // ====================
    // properties
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_read_taken;
        live && reg_rd_in && !reg_wr_in;
    endsequence
    sequence s_cfg_hold;
        cfg_rst [*3];
    endsequence
    a_read_answered: assert property (s_read_taken |=> reg_rvalid_out)
        else $error("read strobe got no answer");
    a_answer_cause: assert property (reg_rvalid_out |-> $past(live && reg_rd_in && !reg_wr_in))
        else $error("answer without a taken read");
    a_rdata_idle: assert property (!reg_rvalid_out |-> reg_rdata_out == 8'h00)
        else $error("read data not zero while idle");
    a_cfg_defaults: assert property (s_cfg_hold |-> !forced_pwm_enable_out &&
        switch_sel_a_out == 2'h2 && ref_code_out == 8'h44)
        else $error("configuration reset did not restore defaults");
    a_run_follows: assert property ($past(reset_n_in) |->
        converter_run_out == $past(!input_undervoltage_lockout_in && enable_in))
        else $error("run output does not follow lockout and enable");
    a_ref_range: assert property (ref_code_out >= 8'h3D && ref_code_out <= 8'hCC)
        else $error("reference code outside clamp range");
    a_ref_one_step: assert property (disable iff (!reset_n_in || quiet != 2'h3)
        ref_code_out == $past(ref_code_out) || ref_code_out == $past(ref_code_out) + 8'h01 ||
        ref_code_out == $past(ref_code_out) - 8'h01)
        else $error("reference jumped more than one code");
    a_ramp_dwell: assert property (disable iff (!reset_n_in || quiet != 2'h3)
        $changed(ref_code_out) |=> $stable(ref_code_out) [*8])
        else $error("reference stepped faster than the fastest rate");
endmodule

bind converter_control_regs conv_regs_checker chk (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .io_supply_valid_in(io_supply_valid_in),
    .input_undervoltage_lockout_in(input_undervoltage_lockout_in), .enable_in(enable_in),
    .host_connected_in(host_connected_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out), .converter_run_out(converter_run_out),
    .forced_pwm_enable_out(forced_pwm_enable_out), .switch_sel_a_out(switch_sel_a_out),
    .ref_code_out(ref_code_out)
);

/* dv/host_model.sv */
`timescale 1ns/1ps
module host_model
    import conv_regs_pkg::*;
(
    input  wire logic       mclk_in,
    input  wire logic       rvalid_in,
    input  wire logic [7:0] rdata_in,
    output logic      [7:0] addr_out,
    output logic      [7:0] wdata_out,
    output logic            wr_out,
    output logic            rd_out
);
    // ====================
    // register access cycles
    initial begin
        addr_out = 8'h00;
        wdata_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk_in);
        #2;
        addr_out = a;
        wdata_out = (a == ADDR_CONTROL_THREE) ? (v | 8'h0C) : v;
        wr_out = 1'b1;
        @(posedge mclk_in);
        #2;
        wr_out = 1'b0;
        wdata_out = ~wdata_out;
    endtask
    // data is unknown when no answer arrives
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk_in);
        #2;
        addr_out = a;
        rd_out = 1'b1;
        @(posedge mclk_in);
        #2;
        rd_out = 1'b0;
        v = rvalid_in ? rdata_in : 8'hXX;
    endtask
endmodule

/* dv/test_converter_control_regs.sv */
`timescale 1ns/1ps
module test_converter_control_regs
    import conv_regs_pkg::*;
;
    // ====================
    // stimulus and observed signals
    logic mclk_in = 1'b0, reset_n_in = 1'b0, io_supply_valid_in = 1'b1, input_undervoltage_lockout_in = 1'b0;
    logic enable_in = 1'b1, host_connected_in = 1'b1, output_in_regulation_in = 1'b0;
    logic [3:0] ev = 4'h0;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, ref_code_out, d;
    logic       reg_wr_in, reg_rd_in, reg_rvalid_out, converter_run_out, forced_pwm_enable_out;
    logic       hs_mode_ext_en_out, power_good_out;
    logic [2:0] current_limit_sel_out, comp_sel_out;
    logic [1:0] switch_sel_a_out;
    int         error_cnt = 0, num_checks = 0, cycles = 0, lo, hi, steps;
    // ramp rates in 1/150 mV per us; one code is 735 of these units
    int         rate [6] = '{175, 200, 100, 50, 25, 34};
    logic [1:0] rcode [6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
    logic [1:0] fcode [6] = '{2'h0, 2'h2, 2'h3, 2'h0, 2'h1, 2'h3};
    logic [7:0] rst_tab [5] = '{8'h0F, 8'h50, 8'h44, 8'h0C, 8'h00};

    converter_control_regs uut (.mclk_in, .reset_n_in, .io_supply_valid_in, .input_undervoltage_lockout_in,
        .enable_in, .host_connected_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in,
        .overvoltage_event_in(ev[3]), .overcurrent_event_in(ev[0]), .hard_short_event_in(ev[2]),
        .thermal_shutdown_event_in(ev[1]), .output_in_regulation_in, .reg_rdata_out, .reg_rvalid_out,
        .converter_run_out, .forced_pwm_enable_out, .hs_mode_ext_en_out, .current_limit_sel_out,
        .switch_sel_a_out, .comp_sel_out, .ref_code_out, .power_good_out);
    host_model host (.mclk_in(mclk_in), .rvalid_in(reg_rvalid_out), .rdata_in(reg_rdata_out),
        .addr_out(reg_addr_in), .wdata_out(reg_wdata_in), .wr_out(reg_wr_in), .rd_out(reg_rd_in));

    always #20 mclk_in = ~mclk_in;
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 60000) begin
            error_cnt++;
            give_verdict();
        end
    end
    // ====================
    // helpers
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge mclk_in);
        #2;
    endtask
    // hold one configuration reset cause for three edges
    task automatic cfg_pulse(input int k);
        wait_n(1);
        io_supply_valid_in = (k != 0);
        input_undervoltage_lockout_in = (k == 1);
        enable_in = (k != 2);
        wait_n(3);
        check(8'(converter_run_out), 8'(k == 0));
        io_supply_valid_in = 1'b1;
        input_undervoltage_lockout_in = 1'b0;
        enable_in = 1'b1;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ====================
    // tests
    initial begin
        wait_n(5);
        reset_n_in = 1'b1;
        for (int i = 0; i < 5; i++) begin
            host.rd(ADDR_FAULT_MASK + 8'(i), d);
            check(d, rst_tab[i]);
        end
        check({switch_sel_a_out, forced_pwm_enable_out, hs_mode_ext_en_out}, 8'h08);
        $display("test reset values done");
        host.wr(ADDR_CONTROL_THREE, 8'h20);
        host.wr(ADDR_SERIAL_CONFIG, 8'h01);
        host.wr(ADDR_CONTROL_ONE, 8'hAB);
        wait_n(2);
        check({6'h00, forced_pwm_enable_out, hs_mode_ext_en_out}, 8'h03);
        check({comp_sel_out, switch_sel_a_out, current_limit_sel_out}, 8'hAB);
        host.rd(ADDR_CONTROL_THREE, d);
        check(d, 8'h2C);
        host.wr(ADDR_CONTROL_THREE, 8'h00);
        host_connected_in = 1'b0;
        host.wr(ADDR_CONTROL_THREE, 8'h20);
        host.rd(ADDR_CONTROL_ONE, d);
        check(d, 8'hXX);
        host_connected_in = 1'b1;
        check(8'(forced_pwm_enable_out), 8'h00);
        host.rd(8'h20, d);
        check(d, 8'h00);
        $display("test fields and bus gating done");
        for (int k = 0; k < 3; k++) begin
            host.wr(ADDR_CONTROL_THREE, 8'h20);
            host.wr(ADDR_SERIAL_CONFIG, 8'h01);
            cfg_pulse(k);
            host.rd(ADDR_CONTROL_THREE, d);
            check(d, 8'h0C);
            host.rd(ADDR_SERIAL_CONFIG, d);
            check(d, 8'h00);
        end
        $display("test configuration reset done");
        output_in_regulation_in = 1'b1;
        host.wr(ADDR_FAULT_MASK, 8'h00);
        wait_n(2);
        check(8'(power_good_out), 8'h01);
        for (int b = 0; b < 4; b++) begin
            ev[b] = 1'b1;
            wait_n(1);
            ev[b] = 1'b0;
            wait_n(1);
            check(8'(power_good_out), 8'h00);
            host.rd(ADDR_FAULT_FLAGS, d);
            check(d, 8'h01 << b);
            host.rd(ADDR_FAULT_FLAGS, d);
            check(d, 8'h00);
        end
        // an event standing at the clearing read keeps its flag
        ev[0] = 1'b1;
        host.rd(ADDR_FAULT_FLAGS, d);
        ev[0] = 1'b0;
        check(d, 8'h01);
        host.rd(ADDR_FAULT_FLAGS, d);
        check(d, 8'h01);
        host.wr(ADDR_FAULT_MASK, 8'h0F);
        ev = 4'hF;
        wait_n(1);
        ev = 4'h0;
        wait_n(1);
        check(8'(power_good_out), 8'h01);
        host.rd(ADDR_FAULT_FLAGS, d);
        check(d, 8'h0F);
        $display("test faults and masks done");
        for (int c = 0; c < 6; c++) begin
            cfg_pulse(1);
            host.wr(ADDR_CONTROL_ONE, {3'h2, fcode[c], 3'h0});
            host.wr(ADDR_CONTROL_THREE, {6'h00, rcode[c]});
            host.wr(ADDR_CONTROL_TWO, 8'hCC);
            wait_n(6000);
            steps = int'(ref_code_out) - int'(8'h44);
            lo = rate[c] * 239 / 735;
            hi = rate[c] * 241 / 735 + 1;
            check(8'(steps >= lo && steps <= hi), 8'h01);
        end
        // a target below the linear range settles on the lowest code
        cfg_pulse(1);
        host.wr(ADDR_CONTROL_TWO, 8'h00);
        wait_n(1500);
        check(ref_code_out, 8'h3D);
        $display("test ramp rates done");
        give_verdict();
    end
endmodule

/* rtl/converter_control_regs.sv */
`timescale 1ns/1ps
module converter_control_regs
    import conv_regs_pkg::*;
(
    input  wire logic       mclk_in,
    input  wire logic       reset_n_in,
    input  wire logic       io_supply_valid_in,
    input  wire logic       input_undervoltage_lockout_in,
    input  wire logic       enable_in,
    input  wire logic       host_connected_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       overvoltage_event_in,
    input  wire logic       overcurrent_event_in,
    input  wire logic       hard_short_event_in,
    input  wire logic       thermal_shutdown_event_in,
    input  wire logic       output_in_regulation_in,
    output logic      [7:0] reg_rdata_out,
    output logic            reg_rvalid_out,
    output logic            converter_run_out,
    output logic            forced_pwm_enable_out,
    output logic            hs_mode_ext_en_out,
    output logic      [2:0] current_limit_sel_out,
    output logic      [1:0] switch_sel_a_out,
    output logic      [2:0] comp_sel_out,
    output logic      [7:0] ref_code_out,
    output logic            power_good_out
);

    // ==========================================================
    // state
    logic [3:0] fault_flags;
    logic [7:0] fault_mask;
    logic [7:0] control_one;
    logic [7:0] control_two;
    logic [7:0] control_three;
    logic [7:0] serial_config;
    logic [7:0] rdata;
    logic       rvalid;
    logic       run;
    logic       forced_pwm;
    logic       hs_mode_ext;
    logic [2:0] current_limit;
    logic [1:0] switch_sel_a;
    logic [2:0] comp;
    logic       pgood;

    logic [3:0] next_fault_flags;
    logic [7:0] next_fault_mask;
    logic [7:0] next_control_one;
    logic [7:0] next_control_two;
    logic [7:0] next_control_three;
    logic [7:0] next_serial_config;
    logic [7:0] next_rdata;
    logic       next_rvalid;
    logic       next_run;
    logic       next_forced_pwm;
    logic       next_hs_mode_ext;
    logic [2:0] next_current_limit;
    logic [1:0] next_switch_sel_a;
    logic [2:0] next_comp;
    logic       next_pgood;

    logic       cfg_reset;
    logic       bus_live;
    logic       wr_hit;
    logic       rd_hit;
    logic [3:0] fault_events;
    logic [3:0] fault_clear;
    logic [3:0] unmasked;
    logic [7:0] ref_code;

    // ==========================================================
    // qualifiers
    always_comb begin
        cfg_reset = !io_supply_valid_in || input_undervoltage_lockout_in || !enable_in;
        bus_live  = io_supply_valid_in && host_connected_in && !cfg_reset;
        wr_hit    = bus_live && reg_wr_in;
        rd_hit    = bus_live && reg_rd_in && !reg_wr_in;
    end

    // ==========================================================
    // fault flags: sticky, cleared by reading, a new event wins over the clear
    always_comb begin
        fault_events = '0;
        fault_events[BIT_OVERCURRENT] = overcurrent_event_in;
        fault_events[BIT_THERMAL]     = thermal_shutdown_event_in;
        fault_events[BIT_HARD_SHORT]  = hard_short_event_in;
        fault_events[BIT_OVERVOLTAGE] = overvoltage_event_in;
        fault_clear = (rd_hit && reg_addr_in == ADDR_FAULT_FLAGS) ? 4'hF : 4'h0;
        if (cfg_reset) begin
            next_fault_flags = 4'h0;
        end else begin
            next_fault_flags = (fault_flags & ~fault_clear) | fault_events;
        end
    end

    // ==========================================================
    // writable registers
    always_comb begin
        next_fault_mask    = fault_mask;
        next_control_one   = control_one;
        next_control_two   = control_two;
        next_control_three = control_three;
        next_serial_config = serial_config;
        if (cfg_reset) begin
            next_fault_mask    = RST_FAULT_MASK;
            next_control_one   = RST_CONTROL_ONE;
            next_control_two   = RST_CONTROL_TWO;
            next_control_three = RST_CONTROL_THREE;
            next_serial_config = RST_SERIAL_CONFIG;
        end else if (wr_hit) begin
            case (reg_addr_in)
                ADDR_FAULT_MASK:    next_fault_mask    = reg_wdata_in;
                ADDR_CONTROL_ONE:   next_control_one   = reg_wdata_in;
                ADDR_CONTROL_TWO:   next_control_two   = reg_wdata_in;
                ADDR_CONTROL_THREE: next_control_three = reg_wdata_in;
                ADDR_SERIAL_CONFIG: next_serial_config = reg_wdata_in;
                default:            next_fault_mask    = fault_mask;
            endcase
        end
    end

    // ==========================================================
    // read port: data one cycle after the strobe
    always_comb begin
        next_rvalid = rd_hit;
        next_rdata  = UNMAPPED_READ;
        if (rd_hit) begin
            case (reg_addr_in)
                ADDR_FAULT_FLAGS:   next_rdata = {4'h0, fault_flags};
                ADDR_FAULT_MASK:    next_rdata = fault_mask;
                ADDR_CONTROL_ONE:   next_rdata = control_one;
                ADDR_CONTROL_TWO:   next_rdata = control_two;
                ADDR_CONTROL_THREE: next_rdata = control_three;
                ADDR_SERIAL_CONFIG: next_rdata = serial_config;
                default:            next_rdata = UNMAPPED_READ;
            endcase
        end
    end

    // ==========================================================
    // control outputs
    always_comb begin
        next_run           = !input_undervoltage_lockout_in && enable_in;
        next_forced_pwm    = control_three[BIT_FORCED_PWM];
        next_hs_mode_ext   = serial_config[BIT_HS_MODE_EXT];
        next_current_limit = control_one[LSB_CURRENT_LIMIT +: 3];
        next_switch_sel_a          = control_one[LSB_SWITCH_SEL_A +: 2];
        next_comp          = control_one[LSB_COMP +: 3];
        unmasked           = fault_flags & ~fault_mask[3:0];
        next_pgood         = (output_in_regulation_in || fault_mask[BIT_PGOOD]) && (unmasked == 4'h0);
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            fault_flags   <= 4'h0;
            fault_mask    <= RST_FAULT_MASK;
            control_one   <= RST_CONTROL_ONE;
            control_two   <= RST_CONTROL_TWO;
            control_three <= RST_CONTROL_THREE;
            serial_config <= RST_SERIAL_CONFIG;
            rdata         <= UNMAPPED_READ;
            rvalid        <= 1'b0;
            run           <= 1'b0;
            forced_pwm    <= RST_CONTROL_THREE[BIT_FORCED_PWM];
            hs_mode_ext   <= RST_SERIAL_CONFIG[BIT_HS_MODE_EXT];
            current_limit <= RST_CONTROL_ONE[LSB_CURRENT_LIMIT +: 3];
            switch_sel_a          <= RST_CONTROL_ONE[LSB_SWITCH_SEL_A +: 2];
            comp          <= RST_CONTROL_ONE[LSB_COMP +: 3];
            pgood         <= 1'b0;
        end else begin
            fault_flags   <= next_fault_flags;
            fault_mask    <= next_fault_mask;
            control_one   <= next_control_one;
            control_two   <= next_control_two;
            control_three <= next_control_three;
            serial_config <= next_serial_config;
            rdata         <= next_rdata;
            rvalid        <= next_rvalid;
            run           <= next_run;
            forced_pwm    <= next_forced_pwm;
            hs_mode_ext   <= next_hs_mode_ext;
            current_limit <= next_current_limit;
            switch_sel_a          <= next_switch_sel_a;
            comp          <= next_comp;
            pgood         <= next_pgood;
        end
    end

    // ==========================================================
    // reference ramp
    ref_ramp u_ref_ramp (
        .mclk_in        (mclk_in),
        .reset_n_in     (reset_n_in),
        .snap_in        (cfg_reset),
        .target_code_in (control_two),
        .ramp_sel_in    (control_three[LSB_RAMP +: 2]),
        .switch_sel_a_sel_in    (control_one[LSB_SWITCH_SEL_A +: 2]),
        .ref_code_out   (ref_code)
    );

    assign reg_rdata_out         = rdata;
    assign reg_rvalid_out        = rvalid;
    assign converter_run_out     = run;
    assign forced_pwm_enable_out = forced_pwm;
    assign hs_mode_ext_en_out    = hs_mode_ext;
    assign current_limit_sel_out = current_limit;
    assign switch_sel_a_out      = switch_sel_a;
    assign comp_sel_out          = comp;
    assign ref_code_out          = ref_code;
    assign power_good_out        = pgood;

endmodule

/* rtl/ref_ramp.sv */
`timescale 1ns/1ps
module ref_ramp
    import conv_regs_pkg::*;
(
    input  wire logic       mclk_in,
    input  wire logic       reset_n_in,
    input  wire logic       snap_in,
    input  wire logic [7:0] target_code_in,
    input  wire logic [1:0] ramp_sel_in,
    input  wire logic [1:0] switch_sel_a_sel_in,
    output logic      [7:0] ref_code_out
);

    logic [4:0]  tick_count;
    logic [11:0] accum;
    logic [7:0]  code;
    logic [4:0]  next_tick_count;
    logic [11:0] next_accum;
    logic [7:0]  next_code;
    logic [11:0] rate;
    logic [7:0]  target;
    logic        fast_switch_sel_a;
    logic        tick;
    logic [11:0] sum;

    // ==========================================================
    // rate decode
    always_comb begin
        fast_switch_sel_a = (switch_sel_a_sel_in == SWITCH_SEL_A_1M8) || (switch_sel_a_sel_in == SWITCH_SEL_A_2M1);
        case (ramp_sel_in)
            2'h0:    rate = fast_switch_sel_a ? RATE_4_3 : RATE_7_6;
            2'h1:    rate = RATE_2_3;
            2'h2:    rate = RATE_1_3;
            2'h3:    rate = fast_switch_sel_a ? RATE_17_75 : RATE_1_6;
            default: rate = RATE_7_6;
        endcase
    end

    // ==========================================================
    // one-microsecond ticks add the rate; each full step of units moves the code one step toward the target
    always_comb begin
        target          = clamp_ref(target_code_in);
        tick            = (tick_count == 5'(US_TICK_CYCLES - 1));
        next_tick_count = tick ? 5'h00 : tick_count + 5'h01;
        next_accum      = accum;
        next_code       = code;
        sum             = accum + rate;
        if (snap_in) begin
            next_code  = clamp_ref(RST_CONTROL_TWO);
            next_accum = 12'h000;
        end else if (code == target) begin
            next_accum = 12'h000;
        end else if (tick) begin
            if (sum >= STEP_UNITS) begin
                next_accum = sum - STEP_UNITS;
                next_code  = (code < target) ? code + 8'h01 : code - 8'h01;
            end else begin
                next_accum = sum;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tick_count <= 5'h00;
            accum      <= 12'h000;
            code       <= RST_CONTROL_TWO;
        end else begin
            tick_count <= next_tick_count;
            accum      <= next_accum;
            code       <= next_code;
        end
    end

    assign ref_code_out = code;

endmodule

/* shared/conv_regs_pkg.sv */
// What this block does
// - bit 5 of control_three selects forced PWM when 1; 0 means automatic skip.
// - ramp code 00 gives 7/6 mV/us at frequency 00/01, 4/3 mV/us at 10/11.
// - ramp code 11 gives 1/6 mV/us at frequency 00/01, 17/75 mV/us at 10/11.
// - serial_config bit 0 enables the high-speed extension; resets to 0.
// - configuration resets on invalid I/O supply, input undervoltage or enable low.
// - register access works only with I/O supply valid and a host connected.
// - overvoltage, overcurrent, hard-short and thermal flags are readable single bits.
// - per-fault masks gate each fault onto the power-good/interrupt output.
// - output target follows the 8-bit reference code, ramped at the selected rate.
// - current limit, frequency and compensation fields are writable at run time.
// - without a host the converter runs on valid input using defaults.
// - frequency field 00/01/10/11 means 1.2/1.5/1.8/2.1 MHz, default 10.
// - reference clamps below 0x3D and above 0xCC, 4.9 mV steps, default 0x44.
package conv_regs_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] ADDR_FAULT_FLAGS   = 8'h10;
    localparam logic [7:0] ADDR_FAULT_MASK    = 8'h11;
    localparam logic [7:0] ADDR_CONTROL_ONE   = 8'h12;
    localparam logic [7:0] ADDR_CONTROL_TWO   = 8'h13;
    localparam logic [7:0] ADDR_CONTROL_THREE = 8'h14;
    localparam logic [7:0] ADDR_SERIAL_CONFIG = 8'h15;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_FAULT_MASK    = 8'h0F;
    localparam logic [7:0] RST_CONTROL_ONE   = 8'h50;
    localparam logic [7:0] RST_CONTROL_TWO   = 8'h44;
    localparam logic [7:0] RST_CONTROL_THREE = 8'h0C;
    localparam logic [7:0] RST_SERIAL_CONFIG = 8'h00;
    localparam logic [7:0] UNMAPPED_READ     = 8'h00;

    // ==========================================================
    // field positions
    localparam int BIT_OVERCURRENT   = 0;
    localparam int BIT_THERMAL       = 1;
    localparam int BIT_HARD_SHORT    = 2;
    localparam int BIT_OVERVOLTAGE   = 3;
    localparam int BIT_PGOOD         = 4;
    localparam int BIT_FORCED_PWM    = 5;
    localparam int BIT_HS_MODE_EXT   = 0;
    localparam int LSB_COMP          = 5;
    localparam int LSB_SWITCH_SEL_A          = 3;
    localparam int LSB_CURRENT_LIMIT = 0;
    localparam int LSB_RAMP          = 0;

    // ==========================================================
    // reference code range
    localparam logic [7:0] REF_CODE_MIN = 8'h3D;
    localparam logic [7:0] REF_CODE_MAX = 8'hCC;

    // ==========================================================
    // ramp timing: rates in units of 1/150 mV per us, one code is 4.9 mV
    localparam int CLOCK_SWITCH_SEL_A_MHZ  = 25;
    localparam int US_TICK_CYCLES  = CLOCK_SWITCH_SEL_A_MHZ;
    localparam logic [11:0] STEP_UNITS     = 12'h2DF;
    localparam logic [11:0] RATE_7_6       = 12'h0AF;
    localparam logic [11:0] RATE_4_3       = 12'h0C8;
    localparam logic [11:0] RATE_2_3       = 12'h064;
    localparam logic [11:0] RATE_1_3       = 12'h032;
    localparam logic [11:0] RATE_1_6       = 12'h019;
    localparam logic [11:0] RATE_17_75     = 12'h022;

    typedef enum logic [1:0] {
        SWITCH_SEL_A_1M2,
        SWITCH_SEL_A_1M5,
        SWITCH_SEL_A_1M8,
        SWITCH_SEL_A_2M1
    } switch_switch_sel_a_t;

    function automatic logic [7:0] clamp_ref(input logic [7:0] code);
        if (code < REF_CODE_MIN) begin
            return REF_CODE_MIN;
        end
        if (code > REF_CODE_MAX) begin
            return REF_CODE_MAX;
        end
        return code;
    endfunction

endpackage
